// *** test/rsi_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsi_top_monitor
(
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        watchdogExpiry,
	input wire logic        watchdogClear,
	input wire logic        haltEntry,
	input wire logic        lowPowerMode,
	input wire logic        pcClear,
	input wire logic        spClear,
	input wire logic        spToTop,
	input wire logic        intDisable,
	input wire logic        wdtTbClear,
	input wire logic        timerOff,
	input wire logic        portsInput,
	input wire logic        coreHold,
	input wire logic        watchdogExpiryFlag,
	input wire logic        powerDownFlag,
	input wire logic [2:0]  resetKind,
	input wire logic [7:0]  voltageSelect
);
	// One domain; reset quiets every check
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog events seen in run state; coreHold low rules out an apply in flight
	sequence dogRun;
		watchdogExpiry && !lowPowerMode && !coreHold;
	endsequence
	sequence dogIdle;
		watchdogExpiry && lowPowerMode && !coreHold;
	endsequence
	sequence idleDone;
		pcClear && spClear && watchdogExpiryFlag && powerDownFlag && resetKind == 3'h4;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	// Limitation: a watchdog pulse inside the soft delay is not modelled here
	a_idle_dog_clear: assert property (dogIdle |-> ##2 idleDone)
		else $error("idle watchdog reset effects wrong");
	a_idle_keeps_state: assert property (dogIdle |-> ##2 voltageSelect == $past(voltageSelect, 2) && !intDisable)
		else $error("idle watchdog reset disturbed other state");
	a_run_dog_flags: assert property (dogRun |-> ##2 watchdogExpiryFlag && powerDownFlag == $past(powerDownFlag, 2) && resetKind == 3'h3 && intDisable && !spClear)
		else $error("run watchdog reset flags wrong");
	a_halt_sets_pdf: assert property (haltEntry && !watchdogExpiry && !coreHold |=> powerDownFlag && !watchdogExpiryFlag)
		else $error("halt entry flags wrong");
	a_clear_flags: assert property (watchdogClear && !haltEntry && !watchdogExpiry && !coreHold |=> !watchdogExpiryFlag && !powerDownFlag)
		else $error("watchdog clear flags wrong");
	a_hard_strobes_tied: assert property (intDisable == timerOff && timerOff == portsInput && portsInput == spToTop && spToTop == wdtTbClear)
		else $error("hard reset strobes disagree");
	a_spclear_idle_only: assert property (spClear |-> pcClear && !spToTop && resetKind == 3'h4)
		else $error("stack clear outside idle watchdog reset");
	a_droop_keeps_vsel: assert property ($rose(resetKind == 3'h2) |=> voltageSelect == $past(voltageSelect))
		else $error("droop reset changed voltage select");
	a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a one cycle answer");
endmodule

bind rsi_top rsi_top_monitor u_mon
(
	.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .watchdogExpiry, .watchdogClear,
	.haltEntry, .lowPowerMode, .pcClear, .spClear, .spToTop, .intDisable, .wdtTbClear,
	.timerOff, .portsInput, .coreHold, .watchdogExpiryFlag, .powerDownFlag, .resetKind,
	.voltageSelect
);

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rsi_regs.svh"

module testbench
	import rsi_pkg::*;
;
	logic        sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [7:0]  wb_adr_i, voltageSelect;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic        externalClearPinN, supplyDroop, watchdogExpiry, watchdogCtrlFault;
	logic        watchdogClear, haltEntry, lowPowerMode, pcClear, spClear, spToTop;
	logic        intDisable, wdtTbClear, timerOff, portsInput, coreHold;
	logic        watchdogExpiryFlag, powerDownFlag;
	logic [2:0]  resetKind;
	int          errors, compares;

	rsi_top u_dut
	(
		.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
		.wb_dat_o, .wb_ack_o, .externalClearPinN, .supplyDroop, .watchdogExpiry,
		.watchdogCtrlFault, .watchdogClear, .haltEntry, .lowPowerMode, .irq, .pcClear,
		.spClear, .spToTop, .intDisable, .wdtTbClear, .timerOff, .portsInput, .coreHold,
		.watchdogExpiryFlag, .powerDownFlag, .resetKind, .voltageSelect
	);

	////////////////////////////////////////////////////////////////////////////////
	// 10 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Run takes about 2900 cycles; a hang is cut off well after, at 10000
	initial
	begin
		#1000000;
		errors++;
		$display("Error at %0t: watchdog timeout", $time);
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle: held until ack is sampled high, then released for a cycle
	task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			errors++;
			$display("Error at %0t: no ack for %h", $time, a);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wbXfer(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wbXfer(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask

	// One-cycle pulse of {expiry, clear, halt}
	task automatic ev(input logic [2:0] m);
		@(posedge sys_clk);
		{watchdogExpiry, watchdogClear, haltEntry} <= m;
		@(posedge sys_clk);
		{watchdogExpiry, watchdogClear, haltEntry} <= 3'h0;
	endtask

	// Settle after n more edges so registered outputs are stable
	task automatic stepN(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic waitKind(input logic [2:0] k, input int lim);
		int n;
		n = 0;
		while (resetKind !== k && n < lim)
		begin
			@(posedge sys_clk);
			n++;
		end
		#1;
		chk(resetKind, k);
	endtask

	task automatic doReset(input int n);
		@(posedge sys_clk);
		rstn <= 1'b0;
		stepN(n);
		chk({pcClear, spToTop, intDisable, wdtTbClear, timerOff, portsInput, coreHold}, 7'h7f);
		@(posedge sys_clk);
		rstn <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; irq status accumulates one bit per reset kind except power-on
	initial
	begin
		{rstn, wb_cyc_i, wb_stb_i, wb_we_i, supplyDroop, lowPowerMode} = 6'h0;
		{watchdogExpiry, watchdogCtrlFault, watchdogClear, haltEntry} = 4'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h1;
		externalClearPinN = 1'b1;
		errors = 0;
		compares = 0;
		doReset(16);
		rd(`RSI_ADR_STATUS, 32'h0);
		rd(`RSI_ADR_GUARD, {24'h0, `RSI_GUARD_POR});
		rd(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_POR});
		ev(3'b001);
		stepN(0);
		chk({watchdogExpiryFlag, powerDownFlag}, 2'b01);
		ev(3'b100);
		stepN(1);
		chk({watchdogExpiryFlag, powerDownFlag, resetKind, intDisable, spClear}, {2'b11, RK_DOG_RUN, 2'b10});
		ev(3'b010);
		stepN(0);
		chk({watchdogExpiryFlag, powerDownFlag}, 2'b00);
		wr(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_V2});
		wr(`RSI_ADR_GUARD, {24'h0, `RSI_GUARD_PIN});
		@(posedge sys_clk);
		lowPowerMode <= 1'b1;
		ev(3'b100);
		stepN(1);
		chk({pcClear, spClear, watchdogExpiryFlag, powerDownFlag, resetKind, intDisable}, {4'hf, RK_DOG_IDLE, 1'b0});
		@(posedge sys_clk);
		lowPowerMode <= 1'b0;
		rd(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_V2});
		rd(`RSI_ADR_GUARD, {24'h0, `RSI_GUARD_PIN});
		// Pin reset only honoured with the guard at its pin code
		@(posedge sys_clk);
		externalClearPinN <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(coreHold, 1'b1);
		externalClearPinN <= 1'b1;
		waitKind(RK_PIN, 20);
		chk({watchdogExpiryFlag, powerDownFlag}, 2'b11);
		rd(`RSI_ADR_GUARD, {24'h0, `RSI_GUARD_POR});
		rd(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_POR});
		// Droop must outlast the filter before it resets
		wr(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_V3});
		@(posedge sys_clk);
		supplyDroop <= 1'b1;
		stepN(1100);
		chk(resetKind, RK_PIN);
		waitKind(RK_DROOP, 300);
		@(posedge sys_clk);
		supplyDroop <= 1'b0;
		chk({watchdogExpiryFlag, powerDownFlag}, 2'b11);
		rd(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_V3});
		chk(voltageSelect, `RSI_VSEL_V3);
		rd(`RSI_ADR_CAUSE, 32'h4);
		wr(`RSI_ADR_CAUSE, 32'h0);
		rd(`RSI_ADR_CAUSE, 32'h0);
		wr(`RSI_ADR_GUARD, 32'h12);
		waitKind(RK_GUARD_SOFT, 700);
		rd(`RSI_ADR_GUARD, {24'h0, `RSI_GUARD_POR});
		rd(`RSI_ADR_CAUSE, 32'h8);
		// Byte lane 0 off: the write is acked and dropped
		wb_sel_i <= 4'h0;
		wr(`RSI_ADR_GUARD, 32'h12);
		wb_sel_i <= 4'h1;
		rd(`RSI_ADR_GUARD, {24'h0, `RSI_GUARD_POR});
		// Corrupt voltage select, then a watchdog control fault
		wr(`RSI_ADR_VSEL, 32'h12);
		waitKind(RK_VSEL_SOFT, 700);
		rd(`RSI_ADR_VSEL, {24'h0, `RSI_VSEL_POR});
		rd(`RSI_ADR_CAUSE, 32'ha);
		@(posedge sys_clk);
		watchdogCtrlFault <= 1'b1;
		@(posedge sys_clk);
		watchdogCtrlFault <= 1'b0;
		waitKind(RK_DOGCTL_SOFT, 700);
		rd(`RSI_ADR_CAUSE, 32'hb);
		// Interrupt raise, mask, clear, then an unmapped read
		rd(`RSI_ADR_IRQ_STAT, 32'hfe);
		wr(`RSI_ADR_IRQ_EN, 32'h10);
		stepN(1);
		chk(irq, 1'b1);
		wr(`RSI_ADR_IRQ_EN, 32'h0);
		stepN(1);
		chk(irq, 1'b0);
		wr(`RSI_ADR_IRQ_EN, 32'h10);
		wr(`RSI_ADR_IRQ_CLR, 32'h10);
		stepN(1);
		chk(irq, 1'b0);
		rd(`RSI_ADR_IRQ_STAT, 32'hee);
		rd(8'h1c, 32'h0);
		// Power-on again in mid-run
		doReset(3);
		rd(`RSI_ADR_STATUS, 32'h0);
		rd(`RSI_ADR_IRQ_STAT, 32'h0);
		conclude();
	end
endmodule

`default_nettype wire

// *** verilog/rsi_delay_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Counts consecutive cycles of run; done pulses on the last one
module rsi_delay_timer
#(
	parameter int unsigned  COUNT = 16
)
(
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	input  wire logic   run,
	output wire logic   done
);

	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;

	// Dropping run restarts the count, so only an unbroken span qualifies
	assign done     = run && (cnt_reg == 16'(COUNT - 1));
	assign cnt_next = (run && !done) ? cnt_reg + 16'h0001 : 16'h0000;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= 16'h0000;
		else
			cnt_reg <= cnt_next;
	end

endmodule
`default_nettype wire

// *** verilog/rsi_pkg.sv ***
package rsi_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0]
	{
		ST_RUN   = 4'b0001,
		ST_HOLD  = 4'b0010,
		ST_DELAY = 4'b0100,
		ST_APPLY = 4'b1000
	} rsi_state_t;

	// Latched reset source; the code is also the interrupt bit index
	typedef enum logic [2:0]
	{
		RK_POWER_ON   = 3'h0,
		RK_PIN        = 3'h1,
		RK_DROOP      = 3'h2,
		RK_DOG_RUN    = 3'h3,
		RK_DOG_IDLE   = 3'h4,
		RK_GUARD_SOFT = 3'h5,
		RK_VSEL_SOFT  = 3'h6,
		RK_DOGCTL_SOFT = 3'h7
	} rsi_kind_t;

endpackage

// *** verilog/rsi_regs.svh ***
`ifndef RSI_REGS_SVH
`define RSI_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Wishbone slave
`define RSI_ADR_STATUS     8'h00
`define RSI_ADR_GUARD      8'h04
`define RSI_ADR_VSEL       8'h08
`define RSI_ADR_CAUSE      8'h0c
`define RSI_ADR_IRQ_STAT   8'h10
`define RSI_ADR_IRQ_CLR    8'h14
`define RSI_ADR_IRQ_EN     8'h18

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RSI_STAT_EXPIRY    0
`define RSI_STAT_PWRDN     1
`define RSI_STAT_KIND_LSB  4
`define RSI_CAUSE_DOGCTL   0
`define RSI_CAUSE_VSEL     1
`define RSI_CAUSE_DROOP    2
`define RSI_CAUSE_GUARD    3

////////////////////////////////////////////////////////////////////////////////
// Reset values and legal codes
`define RSI_GUARD_POR      8'h55
`define RSI_GUARD_PIN      8'haa
`define RSI_VSEL_POR       8'h66
`define RSI_VSEL_V2        8'h55
`define RSI_VSEL_V3        8'h33
`define RSI_VSEL_V4        8'h99
`define RSI_VSEL_V5        8'haa
`define RSI_VSEL_OFF       8'hf0
`define RSI_IRQ_MASK       8'hfe

////////////////////////////////////////////////////////////////////////////////
// Timing: least times, rounded up to whole cycles
`define RSI_CLK_PERIOD_NS  100
`define RSI_T_SRESET_NS    50000
`define RSI_T_DROOP_NS     120000
`define RSI_SRESET_CYC     ((`RSI_T_SRESET_NS + `RSI_CLK_PERIOD_NS - 1) / `RSI_CLK_PERIOD_NS)
`define RSI_DROOP_CYC      ((`RSI_T_DROOP_NS + `RSI_CLK_PERIOD_NS - 1) / `RSI_CLK_PERIOD_NS)

`endif

// *** verilog/rsi_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for pins from outside the clock domain
module rsi_sync
#(
	parameter int unsigned  WIDTH   = 2,
	parameter logic [1:0]   RST_VAL = 2'h0
)
(
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	input  wire logic [WIDTH-1:0]   asyncIn,
	output var  logic [WIDTH-1:0]   syncOut
);

	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= RST_VAL[WIDTH-1:0];
			syncOut  <= RST_VAL[WIDTH-1:0];
		end
		else
		begin
			meta_reg <= asyncIn;
			syncOut  <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// *** verilog/rsi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rsi_regs.svh"

module rsi_top
	import rsi_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           rstn,
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [31:0]    wb_dat_i,
	input  wire logic [3:0]     wb_sel_i,
	output wire logic [31:0]    wb_dat_o,
	output wire logic           wb_ack_o,
	input  wire logic           externalClearPinN,
	input  wire logic           supplyDroop,
	input  wire logic           watchdogExpiry,
	input  wire logic           watchdogCtrlFault,
	input  wire logic           watchdogClear,
	input  wire logic           haltEntry,
	input  wire logic           lowPowerMode,
	output wire logic           irq,
	output wire logic           pcClear,
	output wire logic           spClear,
	output wire logic           spToTop,
	output wire logic           intDisable,
	output wire logic           wdtTbClear,
	output wire logic           timerOff,
	output wire logic           portsInput,
	output wire logic           coreHold,
	output wire logic           watchdogExpiryFlag,
	output wire logic           powerDownFlag,
	output wire logic [2:0]     resetKind,
	output wire logic [7:0]     voltageSelect
);

	////////////////////////////////////////////////////////////////////////////
	// Decoding functions

	// Reset guard accepts only its two function codes
	function automatic logic guard_ok(input logic [7:0] v);
		guard_ok = (v == `RSI_GUARD_POR) || (v == `RSI_GUARD_PIN);
	endfunction

	// Voltage select accepts five levels and the off code
	function automatic logic vsel_ok(input logic [7:0] v);
		vsel_ok = (v == `RSI_VSEL_POR) || (v == `RSI_VSEL_V2) || (v == `RSI_VSEL_V3)
			|| (v == `RSI_VSEL_V4) || (v == `RSI_VSEL_V5) || (v == `RSI_VSEL_OFF);
	endfunction

	// One-hot interrupt bit for a reset source
	function automatic logic [7:0] kind_bit(input rsi_kind_t k);
		kind_bit = 8'h01 << k;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	rsi_state_t     stateReg;
	rsi_state_t     stateNext;
	rsi_kind_t      kindReg;
	rsi_kind_t      kindNext;
	rsi_kind_t      pendKindReg;
	rsi_kind_t      pendKindNext;
	logic           expiryFlagReg;
	logic           expiryFlagNext;
	logic           pwrDnFlagReg;
	logic           pwrDnFlagNext;
	logic [7:0]     guardReg;
	logic [7:0]     guardNext;
	logic [7:0]     vselReg;
	logic [7:0]     vselNext;
	logic [3:0]     causeReg;
	logic [3:0]     causeNext;
	logic [3:0]     causeSet;
	logic [7:0]     irqStatReg;
	logic [7:0]     irqStatNext;
	logic [7:0]     irqEnReg;
	logic [7:0]     irqEnNext;
	logic [7:0]     irqEvent;
	logic           irqReg;
	logic           ackReg;
	logic           ackNext;
	logic [31:0]    datOReg;
	logic [31:0]    rdData;
	logic           pcClearReg;
	logic           spClearReg;
	logic           spTopReg;
	logic           hardInitReg;
	logic           holdReg;
	logic           pinSync;
	logic           droopSync;
	logic           droopDone;
	logic           delayDone;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and timers

	// Clear pin idles high, so it synchronises to 1 under reset
	rsi_sync
	#(
		.WIDTH      (2),
		.RST_VAL    (2'h1)
	)
	u_sync
	(
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.asyncIn    ({supplyDroop, externalClearPinN}),
		.syncOut    ({droopSync, pinSync})
	);

	wire pinFuncClear = (guardReg == `RSI_GUARD_PIN);
	wire pinAsserted  = pinFuncClear && !pinSync;
	// Droop detection is off in idle or sleep and when deselected
	wire droopEnabled = !lowPowerMode && (vselReg != `RSI_VSEL_OFF) && vsel_ok(vselReg);

	// Droop must persist for the full qualifying time
	rsi_delay_timer
	#(
		.COUNT      (`RSI_DROOP_CYC)
	)
	u_droop_filter
	(
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.run        (droopSync && droopEnabled && (stateReg == ST_RUN)),
		.done       (droopDone)
	);

	// Corrupted control codes reset only after the software reset delay
	rsi_delay_timer
	#(
		.COUNT      (`RSI_SRESET_CYC)
	)
	u_soft_delay
	(
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.run        (stateReg == ST_DELAY),
		.done       (delayDone)
	);

	////////////////////////////////////////////////////////////////////////////
	// Source detection and sequencer

	wire guardBad  = !guard_ok(guardReg);
	wire vselBad   = !vsel_ok(vselReg);
	wire softFault = guardBad || vselBad || watchdogCtrlFault;
	wire rsi_kind_t softKind = guardBad ? RK_GUARD_SOFT :
		(vselBad ? RK_VSEL_SOFT : RK_DOGCTL_SOFT);
	wire rsi_kind_t dogKind  = lowPowerMode ? RK_DOG_IDLE : RK_DOG_RUN;

	// Watchdog first in run state; while a pin hold or soft delay is pending it is ignored
	always_comb
	begin
		stateNext    = stateReg;
		kindNext     = kindReg;
		pendKindNext = pendKindReg;
		case (stateReg)
			ST_RUN:
			begin
				if (watchdogExpiry)
				begin
					stateNext = ST_APPLY;
					kindNext  = dogKind;
				end
				else if (pinAsserted)
					stateNext = ST_HOLD;
				else if (droopDone)
				begin
					stateNext = ST_APPLY;
					kindNext  = RK_DROOP;
				end
				else if (softFault)
				begin
					stateNext    = ST_DELAY;
					pendKindNext = softKind;
				end
			end
			ST_HOLD:
			begin
				// Core stays held until the pin returns high
				if (!pinAsserted)
				begin
					stateNext = ST_APPLY;
					kindNext  = RK_PIN;
				end
			end
			ST_DELAY:
			begin
				if (delayDone)
				begin
					stateNext = ST_APPLY;
					kindNext  = pendKindReg;
				end
			end
			ST_APPLY:
				stateNext = ST_RUN;
			default:
				stateNext = ST_RUN;
		endcase
	end

	wire applyNow  = (stateReg == ST_APPLY);
	wire applyWarm = applyNow && (kindReg == RK_DOG_IDLE);
	wire applyHard = applyNow && (kindReg != RK_DOG_IDLE);
	wire applyDog  = applyNow && ((kindReg == RK_DOG_RUN) || (kindReg == RK_DOG_IDLE));

	////////////////////////////////////////////////////////////////////////////
	// Wishbone decode

	wire busReq   = wb_cyc_i && wb_stb_i;
	// Writes land on the edge where the master sees ack
	wire busWrite = busReq && wb_we_i && ackReg && wb_sel_i[0];
	wire guardWr  = busWrite && (wb_adr_i == `RSI_ADR_GUARD);
	wire vselWr   = busWrite && (wb_adr_i == `RSI_ADR_VSEL);
	wire causeWr  = busWrite && (wb_adr_i == `RSI_ADR_CAUSE);
	wire irqClrWr = busWrite && (wb_adr_i == `RSI_ADR_IRQ_CLR);
	wire irqEnWr  = busWrite && (wb_adr_i == `RSI_ADR_IRQ_EN);

	assign ackNext = busReq && !ackReg;

	// Read mux; unmapped and write-only addresses read zero
	assign rdData =
		(wb_adr_i == `RSI_ADR_STATUS)   ? {24'h000000, 1'b0, kindReg, 2'b00,
			pwrDnFlagReg, expiryFlagReg} :
		(wb_adr_i == `RSI_ADR_GUARD)    ? {24'h000000, guardReg} :
		(wb_adr_i == `RSI_ADR_VSEL)     ? {24'h000000, vselReg} :
		(wb_adr_i == `RSI_ADR_CAUSE)    ? {28'h0000000, causeReg} :
		(wb_adr_i == `RSI_ADR_IRQ_STAT) ? {24'h000000, irqStatReg} :
		(wb_adr_i == `RSI_ADR_IRQ_EN)   ? {24'h000000, irqEnReg} :
		32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Flag and register next values; reset actions outrank bus writes

	// Watchdog reset sets expiry; halt and watchdog clear drop it
	assign expiryFlagNext = applyDog ? 1'b1 :
		applyNow ? expiryFlagReg :
		(haltEntry || watchdogClear) ? 1'b0 : expiryFlagReg;
	// Idle expiry and halt entry set power-down; other resets but power-on keep it
	assign pwrDnFlagNext = applyWarm ? 1'b1 :
		applyNow ? pwrDnFlagReg :
		haltEntry ? 1'b1 : (watchdogClear ? 1'b0 : pwrDnFlagReg);

	// Guard returns to its power-up code on all but the warm reset
	assign guardNext = applyHard ? `RSI_GUARD_POR :
		(guardWr ? wb_dat_i[7:0] : guardReg);

	// A genuine droop keeps the selected level
	assign vselNext = (applyHard && (kindReg != RK_DROOP)) ? `RSI_VSEL_POR :
		(vselWr ? wb_dat_i[7:0] : vselReg);

	// Hardware sets cause bits; software may only clear them
	assign causeSet[`RSI_CAUSE_DOGCTL] = applyNow && (kindReg == RK_DOGCTL_SOFT);
	assign causeSet[`RSI_CAUSE_VSEL]   = applyNow && (kindReg == RK_VSEL_SOFT);
	assign causeSet[`RSI_CAUSE_DROOP]  = applyNow && (kindReg == RK_DROOP);
	assign causeSet[`RSI_CAUSE_GUARD]  = applyNow && (kindReg == RK_GUARD_SOFT);
	assign causeNext = (causeWr ? (causeReg & wb_dat_i[3:0]) : causeReg) | causeSet;

	// Sticky events; a set in the clear cycle survives
	assign irqEvent    = applyNow ? (kind_bit(kindReg) & `RSI_IRQ_MASK) : 8'h00;
	assign irqStatNext = (irqStatReg & ~(irqClrWr ? wb_dat_i[7:0] : 8'h00)) | irqEvent;
	assign irqEnNext   = irqEnWr ? (wb_dat_i[7:0] & `RSI_IRQ_MASK) : irqEnReg;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer and source registers; power-on is the async reset itself

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stateReg    <= ST_RUN;
			kindReg     <= RK_POWER_ON;
			pendKindReg <= RK_POWER_ON;
		end
		else
		begin
			stateReg    <= stateNext;
			kindReg     <= kindNext;
			pendKindReg <= pendKindNext;
		end
	end

	// Status flags
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			expiryFlagReg <= 1'b0;
			pwrDnFlagReg  <= 1'b0;
		end
		else
		begin
			expiryFlagReg <= expiryFlagNext;
			pwrDnFlagReg  <= pwrDnFlagNext;
		end
	end

	// Software-visible control registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			guardReg <= `RSI_GUARD_POR;
			vselReg  <= `RSI_VSEL_POR;
			causeReg <= 4'h0;
		end
		else
		begin
			guardReg <= guardNext;
			vselReg  <= vselNext;
			causeReg <= causeNext;
		end
	end

	// Interrupt registers and level output
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irqStatReg <= 8'h00;
			irqEnReg   <= 8'h00;
			irqReg     <= 1'b0;
		end
		else
		begin
			irqStatReg <= irqStatNext;
			irqEnReg   <= irqEnNext;
			irqReg     <= |(irqStatNext & irqEnNext);
		end
	end

	// Bus answer: one wait state, ack for one cycle
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ackReg  <= 1'b0;
			datOReg <= 32'h00000000;
		end
		else
		begin
			ackReg  <= ackNext;
			datOReg <= ackNext ? rdData : datOReg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Core init strobes: all but spClear high through power-on reset, one cycle otherwise; coreHold spans hold and apply

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pcClearReg  <= 1'b1;
			spClearReg  <= 1'b0;
			spTopReg    <= 1'b1;
			hardInitReg <= 1'b1;
			holdReg     <= 1'b1;
		end
		else
		begin
			pcClearReg  <= applyNow;
			spClearReg  <= applyWarm;
			spTopReg    <= applyHard;
			// Warm reset must not touch peripherals
			hardInitReg <= applyHard;
			holdReg     <= (stateNext == ST_HOLD) || (stateNext == ST_APPLY);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flop

	assign wb_ack_o           = ackReg;
	assign wb_dat_o           = datOReg;
	assign irq                = irqReg;
	assign pcClear            = pcClearReg;
	assign spClear            = spClearReg;
	assign spToTop            = spTopReg;
	// One strobe drives all peripheral defaults together
	assign intDisable         = hardInitReg;
	assign wdtTbClear         = hardInitReg;
	assign timerOff           = hardInitReg;
	assign portsInput         = hardInitReg;
	assign coreHold           = holdReg;
	assign watchdogExpiryFlag = expiryFlagReg;
	assign powerDownFlag      = pwrDnFlagReg;
	assign resetKind          = kindReg;
	assign voltageSelect      = vselReg;

endmodule
`default_nettype wire
